// ===== shared/prc_pkg.sv
// constants, types and helpers shared by both ends of the link
// Summary of operation
// [R01] three-bit field picks output drive impedance
// [R02] drive field resets to zero, middle setting
// [R03] clearing top primary bit requests deep sleep
// [R04] deep sleep reached in time, refresh stops
// [R05] select pulse or reset wakes deep sleep
// [R06] deep sleep watches only select and reset
// [R07] host writes secondary upper byte as ones
// [R08] secondary bit seven reserved, reads one
// [R09] secondary bit six selects clock type
// [R10] single-ended mode ignores complementary clock
// [R11] host drives complementary clock, never floating
// [R12] secondary bit five enters retention sleep
// [R13] select low exits retention, clears bit
// [R14] reset ends retention, contents not guaranteed
// [R15] bits four to two pick refreshed region
// [R16] lowest two bits report refresh interval
// [R17] refresh only between host accesses
// [R18] busy refresh raises strobe during command
// [R19] rows refreshed evenly over full interval
// [R20] host ends select before maximum low time; register accesses run their fixed length, uncapped
// [R21] high strobe means doubled initial latency
// [R22] sleep entry delays are cycle parameters
package prc_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int LINK_CK_PERIOD_NS = 400;
	localparam int CK_PERIOD_CYC = LINK_CK_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [3:0] CK_HALF_CYC = 4'(CK_PERIOD_CYC / 2);
	localparam int CR0_DEEP_BIT = 15;
	localparam int CR0_DRIVE_MSB = 14;
	localparam int CR0_DRIVE_LSB = 12;
	localparam int CR0_FIXED_LAT_BIT = 3;
	localparam logic [15:0] CR0_RESET = 16'h8008;
	localparam logic [7:0] CR1_RESV_BYTE = 8'hFF;
	localparam int CR1_RESV_BIT = 7;
	localparam int CR1_CLK_BIT = 6;
	localparam int CR1_HS_BIT = 5;
	localparam int CR1_PAR_MSB = 4;
	localparam int CR1_PAR_LSB = 2;
	localparam logic [2:0] PAR_FULL = 3'h0;
	localparam logic [2:0] PAR_BOT_HALF = 3'h1;
	localparam logic [2:0] PAR_BOT_QTR = 3'h2;
	localparam logic [2:0] PAR_BOT_EIGHTH = 3'h3;
	localparam logic [2:0] PAR_NONE = 3'h4;
	localparam logic [2:0] PAR_TOP_HALF = 3'h5;
	localparam logic [2:0] PAR_TOP_QTR = 3'h6;
	localparam logic [1:0] INTERVAL_STD = 2'h1;
	localparam logic [1:0] INTERVAL_HOT = 2'h2;
	localparam int ARRAY_ROWS = 8192;
	localparam int ROW_W = 13;
	localparam int REFRESH_STD_MS = 64;
	localparam int REFRESH_HOT_MS = 16;
	localparam logic [8:0] ROW_STD_CYC =
		9'(REFRESH_STD_MS * 1000000 / (ARRAY_ROWS * CLK_PERIOD_NS));
	localparam logic [8:0] ROW_HOT_CYC =
		9'(REFRESH_HOT_MS * 1000000 / (ARRAY_ROWS * CLK_PERIOD_NS));
	localparam int CSM_STD_US = 4;
	localparam int CSM_HOT_US = 1;
	localparam logic [7:0] CSM_STD_CK =
		8'(CSM_STD_US * 1000 / (CLK_PERIOD_NS * CK_PERIOD_CYC));
	localparam logic [7:0] CSM_HOT_CK =
		8'(CSM_HOT_US * 1000 / (CLK_PERIOD_NS * CK_PERIOD_CYC));
	localparam int HS_ENTRY_US = 3;
	localparam int HS_ENTRY_CYC = HS_ENTRY_US * 1000 / CLK_PERIOD_NS;
	localparam int DS_ENTRY_CYC = 20;
	localparam int LAT_CK_DEF = 3;
	localparam int REFRESH_CYC_DEF = 4;
	localparam int CMD_READ_BIT = 7;
	localparam int CMD_REG_BIT = 6;
	localparam int CMD_SEL_BIT = 0;
	localparam logic [7:0] CA_PAD = 8'h00;

	typedef enum logic [2:0] {
		P_NORMAL = 3'b000,
		P_DS_WAIT = 3'b001,
		P_DEEP = 3'b011,
		P_HS_WAIT = 3'b100,
		P_RETAIN = 3'b101
	} prc_power_e;

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_XFER = 2'b01,
		H_WAKE = 2'b10
	} prc_host_e;

	function automatic logic prc_in_region(input logic [2:0] code,
		input logic [ROW_W-1:0] row);
		case (code)
			PAR_BOT_HALF: return row[12] == 1'b0;
			PAR_BOT_QTR: return row[12:11] == 2'h0;
			PAR_BOT_EIGHTH: return row[12:10] == 3'h0;
			PAR_NONE: return 1'b0;
			PAR_TOP_HALF: return row[12] == 1'b1;
			PAR_TOP_QTR: return row[12:11] == 2'h3;
			default: return 1'b1;
		endcase
	endfunction : prc_in_region
endpackage : prc_pkg

// ===== shared/prc_link_if.sv
// link wires between the memory end and the host controller
interface prc_link_if;
	logic cs_n;
	logic ck;
	logic ck_n;
	logic reset_n;
	logic [7:0] h_dq_out;
	logic h_dq_oe_n;
	logic [7:0] d_dq_out;
	logic d_dq_oe_n;
	logic d_read_write_strobe_out;
	logic d_read_write_strobe_oe_n;
	logic [7:0] dq;
	logic read_write_strobe;

	// resolved bus levels, undriven reads as pulled
	assign dq = !d_dq_oe_n ? d_dq_out : (!h_dq_oe_n ? h_dq_out : 8'hFF);
	assign read_write_strobe = !d_read_write_strobe_oe_n ? d_read_write_strobe_out : 1'b0;

	modport device (
		input cs_n, ck, ck_n, reset_n, dq,
		output d_dq_out, d_dq_oe_n, d_read_write_strobe_out, d_read_write_strobe_oe_n
	);
	modport host (
		output cs_n, ck, ck_n, reset_n, h_dq_out, h_dq_oe_n,
		input dq, read_write_strobe
	);
endinterface : prc_link_if

// ===== hw/prc_sync.sv
// two-flop synchroniser for pin inputs
module prc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clk) begin
		if (reset) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : prc_sync

// ===== hw/prc_device.sv
// memory end: configuration, power states and self-refresh
module prc_device import prc_pkg::*; #(
	// [R22] sleep entry delays in cycles
	parameter int DS_WAIT_CYC = DS_ENTRY_CYC,
	parameter int HS_WAIT_CYC = HS_ENTRY_CYC,
	parameter int LAT_CK = LAT_CK_DEF,
	parameter int REFRESH_CYC = REFRESH_CYC_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// link
	prc_link_if.device link,
	// environment
	input wire logic hot,
	// status
	output logic deep_sleep,
	output logic retention_sleep,
	output logic contents_valid,
	output logic refresh_busy,
	output logic diff_clock,
	output logic [2:0] drive_strength
);
	if (DS_WAIT_CYC < 1 || DS_WAIT_CYC > 65535 || HS_WAIT_CYC < 1 ||
		HS_WAIT_CYC > 65535 || LAT_CK < 1 || LAT_CK > 60 ||
		REFRESH_CYC < 1 || REFRESH_CYC > 255) begin : g_chk
		$error("prc_device: parameter out of range");
	end

	logic [11:0] pins;
	logic cs_act, ck_s, ckn_s, rstn_s, ck_eff;
	logic [7:0] dq_s;
	logic cs_start, cs_end, rise, tick_wrap, pend_inc, pend_dec;
	logic [8:0] row_cyc;
	logic [7:0] lat_ck;
	logic [15:0] rd_word, wr_word;
	logic [1:0] interval;

	prc_power_e power, next_power;
	logic [15:0] wait_cnt, next_wait_cnt;
	logic [15:0] cr0, next_cr0;
	logic clk_single, next_clk_single;
	logic hs_bit, next_hs_bit;
	logic [2:0] par, next_par;
	logic cs_q, next_cs_q, ck_q, next_ck_q;
	logic xact, next_xact, dlat, next_dlat;
	logic [7:0] rc, next_rc, cmd, next_cmd, whi, next_whi;
	logic [7:0] dq_out, next_dq_out;
	logic dq_oe_n, next_dq_oe_n, read_write_strobe_out, next_read_write_strobe_out;
	logic read_write_strobe_oe_n, next_read_write_strobe_oe_n;
	logic [8:0] tick, next_tick;
	logic [1:0] pend, next_pend;
	logic [7:0] busy_cnt, next_busy_cnt;
	logic [ROW_W-1:0] row, next_row;
	logic next_deep_sleep, next_retention_sleep, next_contents_valid;

	prc_sync #(.W(12)) u_sync (
		.clk(clk),
		.reset(reset),
		.d({~link.cs_n, link.ck, link.ck_n, link.reset_n, link.dq}),
		.q(pins)
	);

	// select synced active high, a cleared stage reads idle
	assign cs_act = pins[11];
	assign ck_s = pins[10];
	assign ckn_s = pins[9];
	assign rstn_s = pins[8];
	assign dq_s = pins[7:0];
	// [R10] complementary clock ignored when single-ended
	assign ck_eff = clk_single ? ck_s : (ck_s & ~ckn_s);
	assign cs_start = cs_act & ~cs_q;
	assign cs_end = ~cs_act & cs_q;
	assign rise = ck_eff & ~ck_q;
	// [R16] interval code reported
	assign interval = hot ? INTERVAL_HOT : INTERVAL_STD;
	assign row_cyc = hot ? ROW_HOT_CYC : ROW_STD_CYC;
	// [R21] doubled latency
	assign lat_ck = dlat ? 8'(2 * LAT_CK) : 8'(LAT_CK);
	// [R08] reserved bits read one
	assign rd_word = cmd[CMD_SEL_BIT] ? {CR1_RESV_BYTE, 1'b1, clk_single,
		hs_bit, par, interval} : cr0;
	assign wr_word = {whi, dq_s};

	assign link.d_dq_out = dq_out;
	assign link.d_dq_oe_n = dq_oe_n;
	assign link.d_read_write_strobe_out = read_write_strobe_out;
	assign link.d_read_write_strobe_oe_n = read_write_strobe_oe_n;
	// [R01] drive field output
	assign drive_strength = cr0[CR0_DRIVE_MSB:CR0_DRIVE_LSB];

	always_comb begin
		next_power = power;
		next_wait_cnt = wait_cnt;
		next_cr0 = cr0;
		next_clk_single = clk_single;
		next_hs_bit = hs_bit;
		next_par = par;
		next_cs_q = cs_act;
		next_ck_q = ck_eff;
		next_xact = xact;
		next_dlat = dlat;
		next_rc = rc;
		next_cmd = cmd;
		next_whi = whi;
		next_dq_out = dq_out;
		next_dq_oe_n = dq_oe_n;
		next_read_write_strobe_out = read_write_strobe_out;
		next_read_write_strobe_oe_n = read_write_strobe_oe_n;
		next_tick = tick;
		next_pend = pend;
		next_busy_cnt = busy_cnt;
		next_row = row;
		next_contents_valid = contents_valid;
		tick_wrap = 1'b0;
		pend_inc = 1'b0;
		pend_dec = 1'b0;
		// [R19] evenly spaced row refresh
		if (power != P_DEEP) begin
			if (busy_cnt != 8'h00)
				next_busy_cnt = busy_cnt - 8'h01;
			tick_wrap = tick >= row_cyc - 9'h001;
			next_tick = tick_wrap ? 9'h000 : tick + 9'h001;
			pend_inc = tick_wrap && pend != 2'h3;
			// [R17] refresh between accesses
			if (pend != 2'h0 && busy_cnt == 8'h00 && !cs_act) begin
				pend_dec = 1'b1;
				next_row = row + 13'h0001;
				// [R15] region select
				if (prc_in_region(par, row))
					next_busy_cnt = 8'(REFRESH_CYC);
			end
			next_pend = pend + {1'b0, pend_inc} - {1'b0, pend_dec};
		end
		unique case (power)
			P_NORMAL: ;
			P_DS_WAIT: begin
				// count once the requesting selection has ended
				if (!cs_act)
					next_wait_cnt = wait_cnt - 16'h0001;
				// [R04] refresh halted, data lost
				if (!cs_act && wait_cnt == 16'h0000) begin
					next_power = P_DEEP;
					next_contents_valid = 1'b0;
					next_pend = 2'h0;
					next_busy_cnt = 8'h00;
				end
			end
			P_DEEP: begin
				// [R05] select pulse wakes
				if (cs_end) begin
					next_power = P_NORMAL;
					next_cr0 = CR0_RESET;
					next_clk_single = 1'b1;
					next_par = PAR_FULL;
				end
			end
			P_HS_WAIT, P_RETAIN: begin
				next_wait_cnt = wait_cnt - 16'h0001;
				if (power == P_HS_WAIT && wait_cnt == 16'h0000)
					next_power = P_RETAIN;
				// [R13] select low exits, bit cleared
				if (cs_start) begin
					next_power = P_NORMAL;
					next_hs_bit = 1'b0;
				end
			end
		endcase
		// [R06] transactions only when awake
		if (power == P_NORMAL && cs_start) begin
			next_xact = 1'b1;
			next_rc = 8'h00;
			next_read_write_strobe_oe_n = 1'b0;
			// [R18] strobe flags refresh
			next_read_write_strobe_out = busy_cnt != 8'h00 || pend != 2'h0 ||
				cr0[CR0_FIXED_LAT_BIT];
			next_dlat = next_read_write_strobe_out;
		end else if (power == P_NORMAL && xact && rise) begin
			next_rc = rc + 8'h01;
			if (rc == 8'h00)
				next_cmd = dq_s;
			if (rc == 8'h01)
				next_read_write_strobe_oe_n = 1'b1;
			if (cmd[CMD_REG_BIT] && !cmd[CMD_READ_BIT] && rc == 8'h02)
				next_whi = dq_s;
			if (cmd[CMD_REG_BIT] && !cmd[CMD_READ_BIT] && rc == 8'h03) begin
				if (!cmd[CMD_SEL_BIT]) begin
					next_cr0 = wr_word;
					// [R03] deep sleep request
					if (!wr_word[CR0_DEEP_BIT]) begin
						next_power = P_DS_WAIT;
						next_wait_cnt = 16'(DS_WAIT_CYC - 1);
					end
				end else begin
					// [R09] clock type bit
					next_clk_single = wr_word[CR1_CLK_BIT];
					next_par = wr_word[CR1_PAR_MSB:CR1_PAR_LSB];
					// [R12] retention sleep entry
					next_hs_bit = wr_word[CR1_HS_BIT];
					if (wr_word[CR1_HS_BIT]) begin
						next_power = P_HS_WAIT;
						next_wait_cnt = 16'(HS_WAIT_CYC - 1);
					end
				end
			end
			if (cmd[CMD_REG_BIT] && cmd[CMD_READ_BIT]) begin
				if (rc == lat_ck + 8'h01) begin
					next_dq_out = rd_word[15:8];
					next_dq_oe_n = 1'b0;
				end
				if (rc == lat_ck + 8'h02)
					next_dq_out = rd_word[7:0];
			end
		end
		if (cs_end) begin
			next_xact = 1'b0;
			next_dq_oe_n = 1'b1;
			next_read_write_strobe_oe_n = 1'b1;
			if (xact && !cmd[CMD_REG_BIT] && !cmd[CMD_READ_BIT] &&
				rc > 8'h02)
				next_contents_valid = 1'b1;
		end
		// [R14] reset pin ends sleep, data lost
		if (!rstn_s) begin
			next_power = P_NORMAL;
			next_cr0 = CR0_RESET;
			next_clk_single = 1'b1;
			next_hs_bit = 1'b0;
			next_par = PAR_FULL;
			next_xact = 1'b0;
			next_dq_oe_n = 1'b1;
			next_read_write_strobe_oe_n = 1'b1;
			next_contents_valid = 1'b0;
		end
		next_deep_sleep = next_power == P_DEEP;
		next_retention_sleep = next_power == P_RETAIN;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			power <= P_NORMAL;
			wait_cnt <= 16'h0000;
			// [R02] drive field resets to zero
			cr0 <= CR0_RESET;
			clk_single <= 1'b1;
			hs_bit <= 1'b0;
			par <= PAR_FULL;
			cs_q <= 1'b0;
			ck_q <= 1'b0;
			xact <= 1'b0;
			dlat <= 1'b0;
			rc <= 8'h00;
			cmd <= 8'h00;
			whi <= 8'h00;
			dq_out <= 8'h00;
			dq_oe_n <= 1'b1;
			read_write_strobe_out <= 1'b0;
			read_write_strobe_oe_n <= 1'b1;
			tick <= 9'h000;
			pend <= 2'h0;
			busy_cnt <= 8'h00;
			row <= 13'h0000;
			deep_sleep <= 1'b0;
			retention_sleep <= 1'b0;
			contents_valid <= 1'b0;
			refresh_busy <= 1'b0;
			diff_clock <= 1'b0;
		end else begin
			power <= next_power;
			wait_cnt <= next_wait_cnt;
			cr0 <= next_cr0;
			clk_single <= next_clk_single;
			hs_bit <= next_hs_bit;
			par <= next_par;
			cs_q <= next_cs_q;
			ck_q <= next_ck_q;
			xact <= next_xact;
			dlat <= next_dlat;
			rc <= next_rc;
			cmd <= next_cmd;
			whi <= next_whi;
			dq_out <= next_dq_out;
			dq_oe_n <= next_dq_oe_n;
			read_write_strobe_out <= next_read_write_strobe_out;
			read_write_strobe_oe_n <= next_read_write_strobe_oe_n;
			tick <= next_tick;
			pend <= next_pend;
			busy_cnt <= next_busy_cnt;
			row <= next_row;
			deep_sleep <= next_deep_sleep;
			retention_sleep <= next_retention_sleep;
			contents_valid <= next_contents_valid;
			refresh_busy <= next_busy_cnt != 8'h00;
			diff_clock <= ~next_clk_single;
		end
	end
endmodule : prc_device

// ===== hw/prc_host.sv
// host end: clock divider, transfers, wake and select time limit
module prc_host import prc_pkg::*; #(
	parameter int LAT_CK = LAT_CK_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// link
	prc_link_if.host link,
	// requests
	input wire logic req_valid,
	input wire logic req_read,
	input wire logic req_reg,
	input wire logic req_sel,
	input wire logic [15:0] req_wdata,
	input wire logic [7:0] req_len,
	input wire logic wake,
	input wire logic link_reset,
	// environment
	input wire logic hot,
	input wire logic diff_mode,
	// answers
	output logic busy,
	output logic [15:0] rdata,
	output logic rdata_valid,
	output logic saw_extra_latency
);
	if (LAT_CK < 1 || LAT_CK > 60) begin : g_chk
		$error("prc_host: parameter out of range");
	end

	logic [8:0] pins;
	logic read_write_strobe_s, fall, rise;
	logic [7:0] dq_s, lat_ck, end_ck, lim_ck;

	prc_host_e state, next_state;
	logic [3:0] div, next_div;
	logic ck, next_ck, ck_n, next_ck_n, cs_n, next_cs_n, rst_n, next_rst_n;
	logic [7:0] dq_out, next_dq_out, hr, next_hr;
	logic dq_oe_n, next_dq_oe_n, dlat, next_dlat;
	logic pend, next_pend, wake_pend, next_wake_pend;
	logic r_read, next_r_read, r_reg, next_r_reg, r_sel, next_r_sel;
	logic [15:0] r_wdata, next_r_wdata;
	logic [7:0] r_len, next_r_len;
	logic next_busy, next_rdata_valid, next_saw;
	logic [15:0] next_rdata;

	prc_sync #(.W(9)) u_sync (
		.clk(clk),
		.reset(reset),
		.d({link.read_write_strobe, link.dq}),
		.q(pins)
	);

	assign read_write_strobe_s = pins[8];
	assign dq_s = pins[7:0];
	assign fall = div == (CK_HALF_CYC << 1) - 4'h1;
	assign rise = div == CK_HALF_CYC - 4'h1;
	assign lat_ck = dlat ? 8'(2 * LAT_CK) : 8'(LAT_CK);
	// [R20] select low time capped for memory transfers
	assign lim_ck = hot ? CSM_HOT_CK : CSM_STD_CK;
	assign end_ck = (r_len < lim_ck) ? r_len : lim_ck;

	assign link.ck = ck;
	assign link.ck_n = ck_n;
	assign link.cs_n = cs_n;
	assign link.reset_n = rst_n;
	assign link.h_dq_out = dq_out;
	assign link.h_dq_oe_n = dq_oe_n;

	always_comb begin
		next_state = state;
		next_div = fall ? 4'h0 : div + 4'h1;
		next_cs_n = cs_n;
		next_rst_n = ~link_reset;
		next_dq_out = dq_out;
		next_dq_oe_n = dq_oe_n;
		next_hr = hr;
		next_dlat = dlat;
		next_pend = pend;
		next_wake_pend = wake_pend | wake;
		next_r_read = r_read;
		next_r_reg = r_reg;
		next_r_sel = r_sel;
		next_r_wdata = r_wdata;
		next_r_len = r_len;
		next_rdata = rdata;
		next_rdata_valid = 1'b0;
		next_saw = saw_extra_latency;
		if (req_valid && !busy) begin
			next_pend = 1'b1;
			next_r_read = req_read;
			next_r_reg = req_reg;
			next_r_sel = req_sel;
			// [R07] reserved byte written as ones
			next_r_wdata = req_sel ? {CR1_RESV_BYTE, req_wdata[7:0]} :
				req_wdata;
			next_r_len = req_len;
		end
		unique case (state)
			H_IDLE: begin
				// [R05] select pulse for wake
				if (fall && wake_pend) begin
					next_wake_pend = 1'b0;
					next_cs_n = 1'b0;
					next_state = H_WAKE;
				end else if (fall && pend) begin
					next_pend = 1'b0;
					next_cs_n = 1'b0;
					next_dq_out = {r_read, r_reg, 5'h00, r_sel};
					next_dq_oe_n = 1'b0;
					next_hr = 8'h00;
					next_state = H_XFER;
				end
			end
			H_XFER: begin
				if (rise) begin
					next_hr = hr + 8'h01;
					// [R21] strobe sampled for latency
					if (hr == 8'h01) begin
						next_dlat = read_write_strobe_s;
						next_saw = read_write_strobe_s;
					end
					if (r_reg && r_read && hr == lat_ck + 8'h02)
						next_rdata[15:8] = dq_s;
					if (r_reg && r_read && hr == lat_ck + 8'h03)
						next_rdata[7:0] = dq_s;
				end
				if (fall) begin
					if (hr == 8'h01)
						next_dq_out = CA_PAD;
					if (hr == 8'h02) begin
						next_dq_out = r_wdata[15:8];
						next_dq_oe_n = !(r_reg && !r_read);
					end
					if (hr == 8'h03)
						next_dq_out = r_wdata[7:0];
					if ((r_reg && !r_read && hr == 8'h04) ||
						(r_reg && r_read && hr == lat_ck + 8'h04) ||
						(!r_reg && hr >= 8'h02 && hr >= end_ck)) begin
						next_cs_n = 1'b1;
						next_dq_oe_n = 1'b1;
						next_rdata_valid = r_reg && r_read;
						next_state = H_IDLE;
					end
				end
			end
			H_WAKE: begin
				if (fall) begin
					next_cs_n = 1'b1;
					next_state = H_IDLE;
				end
			end
			default: next_state = H_IDLE;
		endcase
		// clock stands low outside selections
		next_ck = next_div >= CK_HALF_CYC && next_state != H_IDLE;
		// [R11] complement always driven
		next_ck_n = diff_mode ? ~next_ck : 1'b1;
		next_busy = next_pend || next_wake_pend || next_state != H_IDLE;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= H_IDLE;
			div <= 4'h0;
			ck <= 1'b0;
			ck_n <= 1'b1;
			cs_n <= 1'b1;
			rst_n <= 1'b0;
			dq_out <= 8'h00;
			dq_oe_n <= 1'b1;
			hr <= 8'h00;
			dlat <= 1'b0;
			pend <= 1'b0;
			wake_pend <= 1'b0;
			r_read <= 1'b0;
			r_reg <= 1'b0;
			r_sel <= 1'b0;
			r_wdata <= 16'h0000;
			r_len <= 8'h00;
			busy <= 1'b0;
			rdata <= 16'h0000;
			rdata_valid <= 1'b0;
			saw_extra_latency <= 1'b0;
		end else begin
			state <= next_state;
			div <= next_div;
			ck <= next_ck;
			ck_n <= next_ck_n;
			cs_n <= next_cs_n;
			rst_n <= next_rst_n;
			dq_out <= next_dq_out;
			dq_oe_n <= next_dq_oe_n;
			hr <= next_hr;
			dlat <= next_dlat;
			pend <= next_pend;
			wake_pend <= next_wake_pend;
			r_read <= next_r_read;
			r_reg <= next_r_reg;
			r_sel <= next_r_sel;
			r_wdata <= next_r_wdata;
			r_len <= next_r_len;
			busy <= next_busy;
			rdata <= next_rdata;
			rdata_valid <= next_rdata_valid;
			saw_extra_latency <= next_saw;
		end
	end
endmodule : prc_host

// ===== tb/prc_link_props.sv
// link checker: timing relations on the wires between the two ends
module prc_link_props import prc_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// link wires
	input wire logic cs_n,
	input wire logic reset_n,
	input wire logic read_write_strobe,
	input wire logic d_dq_oe_n,
	input wire logic d_read_write_strobe_oe_n,
	// memory end status
	input wire logic deep_sleep,
	input wire logic retention_sleep,
	input wire logic contents_valid,
	input wire logic refresh_busy
);
	localparam int CSM_CYC = CSM_STD_US * 1000 / CLK_PERIOD_NS;
	logic [7:0] low_cnt;
	logic [7:0] next_low_cnt;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// cycles of the current selection
	always_comb begin
		next_low_cnt = cs_n ? 8'h00 : low_cnt + 8'h01;
	end
	always_ff @(posedge clk) begin
		low_cnt <= reset ? 8'h00 : next_low_cnt;
	end

	deep_quiet_a: assert property (
		deep_sleep |-> d_dq_oe_n && d_read_write_strobe_oe_n)
		else $error("memory end drives the bus in deep sleep");
	deep_wake_a: assert property (
		deep_sleep && $fell(cs_n) ##[1:40] $rose(cs_n) |-> ##[1:8] !deep_sleep)
		else $error("select pulse did not end deep sleep");
	deep_invalid_a: assert property (
		deep_sleep |-> !contents_valid)
		else $error("contents still valid in deep sleep");
	retain_wake_a: assert property (
		retention_sleep && $fell(cs_n) |-> ##[1:8] !retention_sleep)
		else $error("select low did not end retention sleep");
	reset_sleep_a: assert property (
		(!reset_n)[*5] |=> !deep_sleep && !retention_sleep && !contents_valid)
		else $error("link reset left a sleep state or valid contents");
	busy_strobe_a: assert property (
		refresh_busy && !deep_sleep && !retention_sleep && $fell(cs_n)
		|-> ##3 read_write_strobe)
		else $error("strobe low in command phase during refresh");
	sel_refresh_a: assert property (
		(!cs_n)[*4] |-> !$rose(refresh_busy))
		else $error("refresh started during a selection");
	select_limit_a: assert property (
		!cs_n |-> low_cnt <= 8'(CSM_CYC))
		else $error("select held low beyond the maximum time");
endmodule : prc_link_props

// ===== tb/testbench.sv
// self-checking bench: both link ends joined, host driven by directed requests with some random values
`define CHK(act, exp, msg) begin \
	cmp_count++; \
	if ((act) !== (exp)) begin \
		err_count++; \
		$display("CHECK FAILED %0t %s", $time, msg); \
	end \
end

module testbench import prc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic reset, hot, req_valid, req_read, req_reg, req_sel, wake;
	logic link_reset, diff_mode, busy, rdata_valid, saw_extra_latency;
	logic deep_sleep, retention_sleep, contents_valid, refresh_busy;
	logic diff_clock;
	logic [2:0] drive_strength, drv;
	logic [15:0] req_wdata, rdata, rd;
	logic [7:0] req_len;
	int err_count, cmp_count, seed, n, k, r;

	prc_link_if lnk();
	prc_device #(.DS_WAIT_CYC(2), .HS_WAIT_CYC(2), .LAT_CK(2)) i_prc_device (
		.clk(clk), .reset(reset), .link(lnk), .hot(hot),
		.deep_sleep(deep_sleep), .retention_sleep(retention_sleep),
		.contents_valid(contents_valid), .refresh_busy(refresh_busy),
		.diff_clock(diff_clock), .drive_strength(drive_strength));
	prc_host #(.LAT_CK(2)) i_prc_host (
		.clk(clk), .reset(reset), .link(lnk), .req_valid(req_valid),
		.req_read(req_read), .req_reg(req_reg), .req_sel(req_sel),
		.req_wdata(req_wdata), .req_len(req_len), .wake(wake),
		.link_reset(link_reset), .hot(hot), .diff_mode(diff_mode),
		.busy(busy), .rdata(rdata), .rdata_valid(rdata_valid),
		.saw_extra_latency(saw_extra_latency));
	prc_link_props i_prc_link_props (
		.clk(clk), .reset(reset), .cs_n(lnk.cs_n), .reset_n(lnk.reset_n),
		.read_write_strobe(lnk.read_write_strobe), .d_dq_oe_n(lnk.d_dq_oe_n),
		.d_read_write_strobe_oe_n(lnk.d_read_write_strobe_oe_n), .deep_sleep(deep_sleep),
		.retention_sleep(retention_sleep), .contents_valid(contents_valid),
		.refresh_busy(refresh_busy));

	always #25 clk = ~clk;

	task close_out;
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out

	task hang(input string msg);
		err_count++;
		$display("CHECK FAILED %0t %s", $time, msg);
		close_out();
	endtask : hang

	function automatic logic [15:0] cr1(input logic se,
		input logic [2:0] par, input logic h);
		return {8'hFF, 1'b1, se, 1'b0, par, h ? INTERVAL_HOT : INTERVAL_STD};
	endfunction : cr1

	function automatic logic [15:0] cr0(input logic up, input logic [2:0] d);
		return {up, d, 12'h008};
	endfunction : cr0

	// one host request, waits for its end and keeps read data
	task run(input logic rdq, input logic rg, input logic sl,
		input logic [15:0] wd, input logic [7:0] ln);
		int i;
		for (i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk);
		if (i == 100) hang("host stays busy");
		rd = 16'hXXXX;
		req_valid = 1'b1;
		req_read = rdq;
		req_reg = rg;
		req_sel = sl;
		req_wdata = wd;
		req_len = ln;
		@(negedge clk);
		req_valid = 1'b0;
		for (i = 0; i < 400 && busy !== 1'b0; i++) begin
			@(negedge clk);
			if (rdata_valid === 1'b1) rd = rdata;
		end
		if (i == 400) hang("transfer hangs");
		@(negedge clk);
		if (rdata_valid === 1'b1) rd = rdata;
	endtask : run

	task pulse_wake;
		wake = 1'b1;
		@(negedge clk);
		wake = 1'b0;
	endtask : pulse_wake

	// waits for a level on a status flag
	task wait_flag(input int which, input logic lvl, input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			if ((which == 0 ? deep_sleep : retention_sleep) === lvl) return;
			@(negedge clk);
		end
		hang("status flag wait ran out");
	endtask : wait_flag

	// cycles until the next rise of refresh activity
	task gap(output int c);
		logic p;
		c = 0;
		p = 1'b1;
		while (c < 500 && !(p === 1'b0 && refresh_busy === 1'b1)) begin
			p = refresh_busy;
			@(negedge clk);
			c++;
		end
		if (c == 500) hang("no refresh seen");
	endtask : gap

	initial begin
		seed = 32'h2C63;
		{hot, req_valid, req_read, req_reg, req_sel, wake} = 6'h00;
		{link_reset, diff_mode, req_wdata, req_len} = 26'h0000000;
		reset = 1'b1;
		repeat (8) @(negedge clk);
		reset = 1'b0;
		repeat (4) @(negedge clk);
		`CHK(drive_strength, 3'h0, "drive field not cleared")
		run(1'b1, 1'b1, 1'b0, 16'h0000, 8'h00);
		`CHK(rd, CR0_RESET, "primary default")
		run(1'b1, 1'b1, 1'b1, 16'h0000, 8'h00);
		`CHK(rd, cr1(1'b1, PAR_FULL, 1'b0), "secondary default")
		hot = 1'b1;
		run(1'b1, 1'b1, 1'b1, 16'h0000, 8'h00);
		`CHK(rd[1:0], INTERVAL_HOT, "hot interval code")
		hot = 1'b0;
		repeat (3) begin
			drv = 3'($random(seed));
			run(1'b0, 1'b1, 1'b0, cr0(1'b1, drv), 8'h00);
			`CHK(drive_strength, drv, "drive field output")
			run(1'b1, 1'b1, 1'b0, 16'h0000, 8'h00);
			`CHK(rd[15:12], {1'b1, drv}, "drive field readback")
		end
		for (n = 0; n < 7; n++) begin
			r = $random(seed);
			run(1'b0, 1'b1, 1'b1, cr1(1'b1, 3'(n), 1'b0) & {r[7:0], 8'hFF},
				8'h00);
			run(1'b1, 1'b1, 1'b1, 16'h0000, 8'h00);
			`CHK(rd, cr1(1'b1, 3'(n), 1'b0), "region code")
			`CHK(rd[15:8], CR1_RESV_BYTE, "reserved byte not ones")
		end
		diff_mode = 1'b1;
		run(1'b0, 1'b1, 1'b1, cr1(1'b0, PAR_FULL, 1'b0), 8'h00);
		`CHK(diff_clock, 1'b1, "differential not selected")
		`CHK(lnk.ck_n, ~lnk.ck, "complement not driven")
		run(1'b1, 1'b1, 1'b1, 16'h0000, 8'h00);
		`CHK(rd, cr1(1'b0, PAR_FULL, 1'b0), "read in differential")
		run(1'b0, 1'b1, 1'b1, cr1(1'b1, PAR_FULL, 1'b0), 8'h00);
		diff_mode = 1'b0;
		`CHK(diff_clock, 1'b0, "single-ended not selected")
		run(1'b1, 1'b1, 1'b1, 16'h0000, 8'h00);
		`CHK(rd, cr1(1'b1, PAR_FULL, 1'b0), "read in single-ended")
		for (n = 0; n < 2; n++) begin
			hot = n[0];
			gap(k);
			gap(k);
			`CHK(9'(k), n ? ROW_HOT_CYC : ROW_STD_CYC, "row spacing")
		end
		repeat (6) begin
			r = $random(seed);
			hot = r[5];
			run(r[4], 1'b0, 1'b0, 16'h0000, 8'(r[3:0]) + 8'h01);
			`CHK(saw_extra_latency, 1'b1, "fixed latency strobe")
		end
		hot = 1'b0;
		run(1'b0, 1'b0, 1'b0, 16'h0000, 8'h08);
		run(1'b0, 1'b1, 1'b0, cr0(1'b0, 3'h5), 8'h00);
		wait_flag(0, 1'b1, 100);
		`CHK(contents_valid, 1'b0, "contents kept in deep sleep")
		pulse_wake();
		wait_flag(0, 1'b0, 60);
		run(1'b1, 1'b1, 1'b0, 16'h0000, 8'h00);
		`CHK(rd, CR0_RESET, "defaults after deep exit")
		run(1'b0, 1'b1, 1'b1, cr1(1'b1, PAR_BOT_HALF, 1'b0) | 16'h0020, 8'h00);
		wait_flag(1, 1'b1, 200);
		pulse_wake();
		wait_flag(1, 1'b0, 60);
		run(1'b1, 1'b1, 1'b1, 16'h0000, 8'h00);
		`CHK(rd, cr1(1'b1, PAR_BOT_HALF, 1'b0), "sleep bit kept")
		run(1'b0, 1'b1, 1'b1, cr1(1'b1, PAR_BOT_HALF, 1'b0) | 16'h0020, 8'h00);
		wait_flag(1, 1'b1, 200);
		link_reset = 1'b1;
		repeat (6) @(negedge clk);
		link_reset = 1'b0;
		`CHK(retention_sleep, 1'b0, "reset kept retention")
		`CHK(contents_valid, 1'b0, "contents valid after reset")
		repeat (6) @(negedge clk);
		run(1'b1, 1'b1, 1'b1, 16'h0000, 8'h00);
		`CHK(rd, cr1(1'b1, PAR_FULL, 1'b0), "secondary after reset")
		close_out();
	end
endmodule : testbench
